//--- include/trdma_pkg.sv
// shared constants, modes, states and carriers of the tape record transfer engine
package trdma_pkg;
  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int CLK_NS = 20;
  localparam int SETUP_NS = 200;
  localparam int HOLD_NS = 75;
  localparam int DESKEW_NS = 125;
  localparam int NO_MEM_NS = 10000;
  // least times round up, the reply timeout rounds down
  localparam logic [8:0] SETUP_CYC = 9'((SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [8:0] HOLD_CYC = 9'((HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [8:0] DESKEW_CYC = 9'((DESKEW_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [8:0] NO_MEM_CYC = 9'(NO_MEM_NS / CLK_NS);
  localparam logic [6:0] START_WORDS = 7'h40;
  // ----------------------------------------
  // widths and register map
  // ----------------------------------------
  localparam int DW = 16;
  localparam int AW = 5;
  localparam logic [2:0] REG_CTL = 3'h0;
  localparam logic [2:0] REG_PTR = 3'h1;
  localparam logic [2:0] REG_MCNT = 3'h2;
  localparam logic [2:0] REG_ERR = 3'h3;
  localparam logic [2:0] REG_OUTW = 3'h4;
  localparam logic [2:0] REG_DCNT = 3'h5;
  localparam int CTL_GO = 0;
  localparam int CTL_READY = 7;
  localparam int CTL_EXT = 8;
  localparam int ERR_NO_MEM = 0;
  localparam int ERR_XFER = 1;
  localparam int ERR_CMP = 2;
  localparam int ERR_TALLY = 9;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // function codes, control bits 5..1
  localparam logic [4:0] FN_WRITE = 5'h18;
  localparam logic [4:0] FN_READ = 5'h1C;
  localparam logic [4:0] FN_WCHK = 5'h14;

  typedef enum logic [1:0] {
    MODE_NONE = 2'b00,
    MODE_WRITE = 2'b01,
    MODE_READ = 2'b10,
    MODE_WCHK = 2'b11
  } trdma_mode_t;

  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_REQ = 3'b001,
    M_SETUP = 3'b010,
    M_STROBE = 3'b011,
    M_DESKEW = 3'b100,
    M_HOLD = 3'b101
  } trdma_mem_st_t;

  typedef struct packed {
    logic [17:0] addr;
    logic [DW-1:0] wdata;
    logic we;
    logic strobe;
  } trdma_mem_req_t;
endpackage

//--- hdl/trdma_sync.sv
// two flip-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
module trdma_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_r <= '0;
      q_o <= '0;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule

//--- hdl/trdma_queue.sv
// staging queue between input and output holding words
`timescale 1ns/1ps
module trdma_queue #(
  parameter int W = 16,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic flush_i,
  // filling side
  input wire logic push_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_rdy_o,
  // draining side
  input wire logic pop_i,
  output logic out_vld_o,
  output logic [W-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } trdma_q_t;
  trdma_q_t s, n;
  logic [W-1:0] cell_r [DEPTH];

  assign in_rdy_o = (s.cnt != (PW+1)'(DEPTH));
  assign out_vld_o = (s.cnt != '0);
  assign out_data_o = cell_r[s.rp];

  always_comb begin
    n = s;
    if (push_i && in_rdy_o) begin
      n.wp = (s.wp == PW'(DEPTH - 1)) ? '0 : s.wp + 1'b1;
    end
    if (pop_i && out_vld_o) begin
      n.rp = (s.rp == PW'(DEPTH - 1)) ? '0 : s.rp + 1'b1;
    end
    n.cnt = s.cnt + (PW+1)'(push_i && in_rdy_o) - (PW+1)'(pop_i && out_vld_o);
    if (flush_i) begin
      n = '0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push_i && in_rdy_o) begin
      cell_r[s.wp] <= in_data_i;
    end
  end
endmodule

//--- hdl/trdma_top.sv
// tape record transfer engine: register slave, memory cycles and drive bus sequencing
`timescale 1ns/1ps
// What this block does
// - echo each drive sync clock pulse back as write strobe during writes.
// - output holding word sits on drive data lines; drive takes it on write strobe.
// - sync clock trailing edge on write reloads output word from last queue cell.
// - drive counter starts at memory counter value, steps by one per drive word.
// - drive counter overflow on write drops the connect line.
// - end-of-record while disconnected ends the transfer and returns to ready.
// - connect still high at end-of-record trailing edge sets frame tally error bit 9.
// - function code and launch bit in control bits 5..0 go to drive and pick path.
// - launched transfer reports busy and refuses further transfer commands.
// - on read, connect; each trailing sync edge captures word and steps drive counter.
// - drive counter overflow on read drops connect and ignores further words.
// - read ends at record end only after memory write cycles have finished.
// - word in output holding word requests bus and steps memory counter.
// - address is pointer plus control bits 8,9; strobe follows 200 ns later.
// - after reply drop strobe, keep address and data 75 ns more.
// - pointer advances by two after each memory word that got a reply.
// - keep bus one more cycle if next word waits, else release.
// - memory cycles stop on counter overflow, transfer or compare error; ready after record end.
// - write-check reads memory word and compares it with output holding word.
// - mismatch sets compare flag and freezes the tape word for software.
// - write-check read waits 125 ns after reply before dropping strobe.
// - on write, connect only after 64 words, counter overflow or transfer error.
// - no reply within 10 us of strobe sets no-memory and transfer errors.
module trdma_top import trdma_pkg::*; #(
  parameter int QDEPTH = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // register bus, axi4-lite
  input wire logic axi_awvalid_i,
  output logic axi_awready_o,
  input wire logic [AW-1:0] axi_awaddr_i,
  input wire logic axi_wvalid_i,
  output logic axi_wready_o,
  input wire logic [31:0] axi_wdata_i,
  input wire logic [3:0] axi_wstrb_i,
  output logic axi_bvalid_o,
  input wire logic axi_bready_i,
  output logic [1:0] axi_bresp_o,
  input wire logic axi_arvalid_i,
  output logic axi_arready_o,
  input wire logic [AW-1:0] axi_araddr_i,
  output logic axi_rvalid_o,
  input wire logic axi_rready_i,
  output logic [31:0] axi_rdata_o,
  output logic [1:0] axi_rresp_o,
  // host memory bus
  output logic bus_master_request_o,
  input wire logic bus_grant_i,
  output logic bus_own_o,
  output trdma_mem_req_t mem_o,
  input wire logic slave_reply_i,
  input wire logic [DW-1:0] mem_rdata_i,
  // drive bus
  output logic [5:0] drv_func_o,
  output logic drv_func_load_o,
  output logic drv_connect_o,
  input wire logic drv_sync_clk_i,
  output logic drv_write_clk_o,
  input wire logic end_of_record_pulse_i,
  input wire logic [DW-1:0] drv_data_i,
  output logic [DW-1:0] drv_data_o,
  output logic drv_data_oe_o
);
  typedef struct packed {
    logic busy;
    trdma_mode_t mode;
    logic [5:0] fn;
    logic [1:0] ext;
    logic [15:0] ptr;
    logic [15:0] mem_cnt;
    logic [15:0] drv_cnt;
    logic mem_cnt_ovf;
    logic drv_cnt_ovf;
    logic no_mem_err;
    logic xfer_err;
    logic tally_err;
    logic cmp_err;
    logic [DW-1:0] in_word;
    logic in_full;
    logic [DW-1:0] out_word;
    logic out_full;
    logic [6:0] start_cnt;
    logic started;
    logic connect;
    logic data_oe;
    logic wclk;
    logic sc_prev;
    logic eor_prev;
    logic rec_end;
    trdma_mem_st_t m;
    logic [8:0] cnt;
    logic second;
    logic req;
    logic own;
    trdma_mem_req_t mem;
    logic fn_load;
    logic aw_got;
    logic w_got;
    logic [2:0] aw_idx;
    logic [15:0] wdata;
    logic wr_en;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [15:0] rdata;
    logic [1:0] rresp;
  } trdma_state_t;

  trdma_state_t s, n;
  logic rst_n;
  logic [DW+DW+3:0] raw_in, syn_in;
  logic sc, eor, reply, grant;
  logic [DW-1:0] rdata_s, drv_data_s;
  logic sc_rise, sc_fall, eor_fall, go, mstop, wr_mode, q_push, q_pop, q_rdy, q_vld;
  logic [DW-1:0] q_data;

  // ----------------------------------------
  // reset release and input sampling
  // ----------------------------------------
  trdma_sync #(.W(1)) u_rst (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .d_i(1'b1),
    .q_o(rst_n)
  );

  // data rides the same two stages as its strobes, so they stay aligned
  assign raw_in = {drv_data_i, mem_rdata_i, bus_grant_i, slave_reply_i, end_of_record_pulse_i, drv_sync_clk_i};
  trdma_sync #(.W(DW + DW + 4)) u_in (
    .clk_i(clk_i),
    .rstn_i(rst_n),
    .d_i(raw_in),
    .q_o(syn_in)
  );
  assign {drv_data_s, rdata_s, grant, reply, eor, sc} = syn_in;

  assign sc_rise = sc && !s.sc_prev;
  assign sc_fall = !sc && s.sc_prev;
  assign eor_fall = !eor && s.eor_prev;
  assign mstop = s.xfer_err || s.cmp_err;
  assign wr_mode = (s.mode == MODE_WRITE);

  trdma_queue #(.W(DW), .DEPTH(QDEPTH)) u_queue (
    .clk_i(clk_i),
    .rstn_i(rst_n),
    .flush_i(go),
    .push_i(q_push),
    .in_data_i(s.in_word),
    .in_rdy_o(q_rdy),
    .pop_i(q_pop),
    .out_vld_o(q_vld),
    .out_data_o(q_data)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    n = s;
    n.fn_load = 1'b0;
    n.sc_prev = sc;
    n.eor_prev = eor;
    q_push = 1'b0;
    q_pop = 1'b0;
    go = 1'b0;
    // register writes; hardware sets below win over software clears
    if (axi_awvalid_i && s.awready) begin
      n.aw_got = 1'b1;
      n.aw_idx = axi_awaddr_i[AW-1:2];
    end
    if (axi_wvalid_i && s.wready) begin
      n.w_got = 1'b1;
      n.wdata = axi_wdata_i[15:0];
      n.wr_en = |axi_wstrb_i[1:0];
    end
    if (s.bvalid && axi_bready_i) begin
      n.bvalid = 1'b0;
    end
    if (n.aw_got && n.w_got && !n.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      case (n.aw_idx)
        REG_CTL: if (n.wr_en && !s.busy) begin
          n.ext = n.wdata[CTL_EXT+1:CTL_EXT];
          n.fn = n.wdata[5:0];
          n.fn_load = n.wdata[CTL_GO];
          go = n.wdata[CTL_GO] && (n.wdata[5:1] == FN_WRITE || n.wdata[5:1] == FN_READ
            || n.wdata[5:1] == FN_WCHK);
        end
        REG_PTR: if (n.wr_en && !s.busy) n.ptr = n.wdata;
        REG_MCNT: if (n.wr_en && !s.busy) n.mem_cnt = n.wdata;
        REG_ERR: if (n.wr_en) begin
          n.no_mem_err = s.no_mem_err && !n.wdata[ERR_NO_MEM];
          n.xfer_err = s.xfer_err && !n.wdata[ERR_XFER];
          n.cmp_err = s.cmp_err && !n.wdata[ERR_CMP];
          n.tally_err = s.tally_err && !n.wdata[ERR_TALLY];
        end
        REG_OUTW, REG_DCNT: ;
        default: n.bresp = RESP_SLVERR;
      endcase
    end
    n.awready = !n.aw_got && !n.bvalid;
    n.wready = !n.w_got && !n.bvalid;
    // register reads
    if (axi_arvalid_i && s.arready) begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      n.rdata = RST_WORD;
      case (axi_araddr_i[AW-1:2])
        REG_CTL: begin
          n.rdata[5:0] = s.fn;
          n.rdata[CTL_READY] = !s.busy;
          n.rdata[CTL_EXT+1:CTL_EXT] = s.ext;
        end
        REG_PTR: n.rdata = s.ptr;
        REG_MCNT: n.rdata = s.mem_cnt;
        REG_ERR: begin
          n.rdata[ERR_NO_MEM] = s.no_mem_err;
          n.rdata[ERR_XFER] = s.xfer_err;
          n.rdata[ERR_CMP] = s.cmp_err;
          n.rdata[ERR_TALLY] = s.tally_err;
        end
        REG_OUTW: n.rdata = s.out_word;
        REG_DCNT: n.rdata = s.drv_cnt;
        default: n.rresp = RESP_SLVERR;
      endcase
    end else if (s.rvalid && axi_rready_i) begin
      n.rvalid = 1'b0;
    end
    n.arready = !n.rvalid;

    // launch: pick the data path and arm both sides
    if (go) begin
      n.busy = 1'b1;
      n.mode = (n.wdata[5:1] == FN_WRITE) ? MODE_WRITE :
        (n.wdata[5:1] == FN_READ) ? MODE_READ : MODE_WCHK;
      n.drv_cnt = s.mem_cnt;
      n.connect = (n.wdata[5:1] != FN_WRITE);
      {n.in_full, n.out_full, n.started, n.rec_end} = 4'h0;
      {n.mem_cnt_ovf, n.drv_cnt_ovf} = 2'h0;
      {n.no_mem_err, n.xfer_err, n.cmp_err, n.tally_err} = 4'h0;
      n.start_cnt = '0;
    end

    // ----------------------------------------
    // drive side
    // ----------------------------------------
    if (s.in_full && q_rdy) begin
      q_push = 1'b1;
      n.in_full = 1'b0;
    end
    if (s.start_cnt == START_WORDS || s.mem_cnt_ovf || s.xfer_err) begin
      n.started = 1'b1;
    end
    // connect only with a word ready, so the drive never sees an empty first slot
    if (s.busy && wr_mode && s.started && s.out_full && !s.connect && !s.drv_cnt_ovf
        && !s.rec_end) begin
      n.connect = 1'b1;
      n.data_oe = 1'b1;
    end
    if (sc_rise && s.connect && wr_mode) begin
      n.wclk = 1'b1;
    end
    if (sc_fall) begin
      n.wclk = 1'b0;
    end
    if (s.busy && sc_fall && s.connect) begin
      n.drv_cnt = s.drv_cnt + 16'h0001;
      if (n.drv_cnt == 16'h0000) begin
        n.connect = 1'b0;
        n.data_oe = 1'b0;
        n.drv_cnt_ovf = 1'b1;
      end
      if (wr_mode) begin
        if (q_vld) begin
          n.out_word = q_data;
          q_pop = 1'b1;
        end else begin
          n.out_full = 1'b0;
          // late data: queue ran dry before the record was complete
          if (n.drv_cnt != 16'h0000) n.xfer_err = 1'b1;
        end
      end else begin
        if (n.in_full) n.xfer_err = 1'b1;
        n.in_word = drv_data_s;
        n.in_full = 1'b1;
      end
    end else if (s.busy && !s.out_full && q_vld && (wr_mode || !s.mem_cnt_ovf)) begin
      n.out_word = q_data;
      n.out_full = 1'b1;
      q_pop = 1'b1;
      if (!wr_mode) begin
        n.mem_cnt = s.mem_cnt + 16'h0001;
        if (n.mem_cnt == 16'h0000) n.mem_cnt_ovf = 1'b1;
      end
    end
    if (s.busy && eor && !s.connect) begin
      n.rec_end = 1'b1;
    end
    if (s.busy && eor_fall && s.connect) begin
      n.tally_err = 1'b1;
      n.connect = 1'b0;
      n.data_oe = 1'b0;
      n.rec_end = 1'b1;
    end
    // read waits for the queue to drain into memory unless an error froze it
    if (s.busy && s.rec_end && s.m == M_IDLE
        && (wr_mode || mstop || (!s.in_full && !q_vld && !s.out_full))) begin
      n.busy = 1'b0;
      n.mode = MODE_NONE;
      n.connect = 1'b0;
      n.data_oe = 1'b0;
    end

    // ----------------------------------------
    // memory side
    // ----------------------------------------
    unique case (s.m)
      M_IDLE: begin
        if (s.busy && !mstop && (wr_mode ? (!s.mem_cnt_ovf && !s.in_full) : s.out_full)) begin
          n.m = M_REQ;
          n.req = 1'b1;
          n.second = 1'b0;
        end
      end
      M_REQ: begin
        if (grant) begin
          n.req = 1'b0;
          n.own = 1'b1;
          n.m = M_SETUP;
          n.cnt = '0;
        end
      end
      M_SETUP: begin
        n.cnt = s.cnt + 9'h001;
        // latch two cycles late: a sync fall may push the refill back by one
        if (s.cnt == 9'h002) begin
          n.mem.addr = {s.ext, s.ptr};
          n.mem.wdata = s.out_word;
          n.mem.we = (s.mode == MODE_READ);
        end
        if (s.cnt == SETUP_CYC + 9'h002) begin
          n.mem.strobe = 1'b1;
          n.m = M_STROBE;
          n.cnt = '0;
        end
      end
      M_STROBE: begin
        n.cnt = s.cnt + 9'h001;
        if (reply) begin
          n.cnt = '0;
          if (s.mode == MODE_WCHK) begin
            n.m = M_DESKEW;
          end else begin
            n.mem.strobe = 1'b0;
            n.m = M_HOLD;
          end
          if (wr_mode) begin
            n.in_word = rdata_s;
            n.in_full = 1'b1;
            n.mem_cnt = s.mem_cnt + 16'h0001;
            if (n.mem_cnt == 16'h0000) n.mem_cnt_ovf = 1'b1;
            if (s.start_cnt != START_WORDS) n.start_cnt = s.start_cnt + 7'h01;
          end
        end else if (s.cnt == NO_MEM_CYC - 9'h001) begin
          n.no_mem_err = 1'b1;
          n.xfer_err = 1'b1;
          n.mem.strobe = 1'b0;
          n.m = M_HOLD;
          n.cnt = '0;
        end
      end
      M_DESKEW: begin
        n.cnt = s.cnt + 9'h001;
        if (s.cnt == DESKEW_CYC - 9'h001) begin
          n.mem.strobe = 1'b0;
          n.m = M_HOLD;
          n.cnt = '0;
          if (rdata_s != s.out_word) n.cmp_err = 1'b1;
        end
      end
      M_HOLD: begin
        n.cnt = s.cnt + 9'h001;
        if (s.cnt == HOLD_CYC - 9'h001) begin
          n.cnt = '0;
          if (!s.no_mem_err) n.ptr = s.ptr + 16'h0002;
          if (!wr_mode && !s.cmp_err && !s.no_mem_err) n.out_full = 1'b0;
          if (!s.second && !mstop && !s.mem_cnt_ovf && (wr_mode ? !s.in_full : q_vld)) begin
            n.second = 1'b1;
            n.m = M_SETUP;
          end else begin
            n.own = 1'b0;
            n.m = M_IDLE;
          end
        end
      end
      default: n.m = M_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign axi_awready_o = s.awready;
  assign axi_wready_o = s.wready;
  assign axi_bvalid_o = s.bvalid;
  assign axi_bresp_o = s.bresp;
  assign axi_arready_o = s.arready;
  assign axi_rvalid_o = s.rvalid;
  assign axi_rdata_o = {16'h0000, s.rdata};
  assign axi_rresp_o = s.rresp;
  assign bus_master_request_o = s.req;
  assign bus_own_o = s.own;
  assign mem_o = s.mem;
  assign drv_func_o = s.fn;
  assign drv_func_load_o = s.fn_load;
  assign drv_connect_o = s.connect;
  assign drv_write_clk_o = s.wclk;
  assign drv_data_o = s.out_word;
  assign drv_data_oe_o = s.data_oe;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  AST_ECHO: assert property (
    sc_rise && s.connect && wr_mode |=> drv_write_clk_o) else $error("sync pulse not echoed");
  AST_PRESENT: assert property (
    $rose(drv_write_clk_o) |-> drv_data_oe_o && $stable(drv_data_o)) else $error("data not presented");
  AST_RELOAD: assert property (
    s.busy && sc_fall && s.connect && wr_mode && q_vld |=> s.out_word == $past(q_data))
    else $error("output word not reloaded");
  AST_DRV_STEP: assert property (
    s.busy && sc_fall && s.connect |=> s.drv_cnt == $past(s.drv_cnt) + 16'h0001)
    else $error("drive counter did not step");
  AST_DROP: assert property (
    s.busy && sc_fall && s.connect && s.drv_cnt == 16'hFFFF |=> !drv_connect_o ##1 !drv_connect_o)
    else $error("connect held after overflow");
  AST_TALLY: assert property (
    s.busy && eor_fall && s.connect |=> s.tally_err) else $error("frame tally error missed");
  AST_BUSY: assert property (
    go |=> s.busy && drv_func_load_o) else $error("launch not taken");
  AST_CAPTURE: assert property (
    s.busy && sc_fall && s.connect && !wr_mode |=> s.in_full && s.in_word == $past(drv_data_s))
    else $error("read word not captured");
  AST_SETUP: assert property (
    $rose(mem_o.strobe) |-> $past(mem_o.addr, 10) == mem_o.addr) else $error("address setup short");
  AST_HOLD: assert property (
    $fell(mem_o.strobe) |-> $stable(mem_o.addr) [*4]) else $error("address changed in hold");
  AST_DESKEW: assert property (
    s.m == M_STROBE && reply && s.mode == MODE_WCHK |=> mem_o.strobe [*7])
    else $error("strobe dropped before deskew");
  AST_NO_MEM: assert property (
    s.m == M_STROBE && !reply && s.cnt == NO_MEM_CYC - 9'h001 |=> s.no_mem_err && s.xfer_err)
    else $error("reply timeout not flagged");

  COV_WRITE_WORD: cover property (s.busy && sc_fall && s.connect && wr_mode);
  COV_DONE: cover property ($fell(s.busy));
  COV_MISMATCH: cover property ($rose(s.cmp_err));
endmodule

//--- verif/trdma_partner.sv
// host memory and tape drive stand-in for the transfer engine bench
`timescale 1ns/1ps
module trdma_partner import trdma_pkg::*; (
  // clock and knobs
  input wire logic clk_i,
  input wire logic slow_i,
  input wire logic bad_i,
  // memory side
  input wire logic req_i,
  output logic grant_o,
  input wire trdma_mem_req_t mem_i,
  output logic reply_o,
  output logic [DW-1:0] mrd_o,
  // drive side
  input wire logic connect_i,
  input wire logic wclk_i,
  input wire logic [DW-1:0] wdat_i,
  output logic sync_o,
  output logic eor_o,
  output logic [DW-1:0] dat_o
);
  logic [DW-1:0] m [0:255];
  logic [DW-1:0] cap [0:15];
  int ncap;
  int w;
  int k;
  // ----------------------------------------
  // memory
  // ----------------------------------------
  always @(posedge clk_i) grant_o <= req_i;
  // reply held until strobe drops; stale data never matches; top address bit is a dead bank
  always @(posedge clk_i) begin
    if (!mem_i.strobe) begin
      w <= 0;
      reply_o <= 1'b0;
      mrd_o <= ~mem_i.wdata;
    end else if (w < (slow_i ? 30 : 2) || mem_i.addr[17]) begin
      w <= w + 1;
    end else begin
      reply_o <= 1'b1;
      mrd_o <= m[mem_i.addr[8:1]];
      if (mem_i.we && !reply_o) m[mem_i.addr[8:1]] <= mem_i.wdata;
    end
  end
  // ----------------------------------------
  // drive
  // ----------------------------------------
  initial begin
    {sync_o, eor_o, dat_o} = '0;
    forever begin
      @(posedge connect_i);
      #405; // record gap before the first sync, off the clock edge
      k = 0;
      while (connect_i && k < 16) begin
        dat_o = (16'hA500 + 16'(k)) ^ {15'h0000, bad_i}; // word as assembled from frames
        sync_o = 1'b1;
        #80;
        sync_o = 1'b0;
        #40;
        dat_o = ~dat_o;
        #40;
        k++;
      end
      #200;
      eor_o = 1'b1;
      #100;
      eor_o = 1'b0;
    end
  end
  always @(posedge wclk_i) begin // word taken on the echoed strobe
    if (ncap < 16) begin
      cap[ncap] <= wdat_i;
      ncap <= ncap + 1;
    end
  end
endmodule

//--- verif/tape_record_transfer_dma_tb.sv
// self-checking bench: register bus tasks driving read, write and write-check records
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin n_mismatch++; $display("mismatch %s exp %h got %h", nm, e, s); end end
module tape_record_transfer_dma_tb import trdma_pkg::*;;
  logic clk_i = 0, rstn_i = 0, slow_i = 0, bad_i = 0;
  logic axi_awvalid_i = 0, axi_wvalid_i = 0, axi_bready_i = 0, axi_arvalid_i = 0, axi_rready_i = 0;
  logic [AW-1:0] axi_awaddr_i = '0, axi_araddr_i = '0;
  logic [31:0] axi_wdata_i = '0, axi_rdata_o, d;
  logic [3:0] axi_wstrb_i = 4'hF;
  logic axi_awready_o, axi_wready_o, axi_bvalid_o, axi_arready_o, axi_rvalid_o, bus_master_request_o, bus_grant_i;
  logic bus_own_o, slave_reply_i, drv_func_load_o, drv_connect_o, drv_sync_clk_i, drv_write_clk_o;
  logic end_of_record_pulse_i, drv_data_oe_o;
  logic [1:0] axi_bresp_o, axi_rresp_o, e;
  trdma_mem_req_t mem_o;
  logic [DW-1:0] mem_rdata_i, drv_data_i, drv_data_o;
  logic [5:0] drv_func_o;
  int n_mismatch = 0, n_tests = 0, i;
  always #10 clk_i = ~clk_i;
  trdma_top dut_u (.clk_i, .rstn_i, .axi_awvalid_i, .axi_awready_o, .axi_awaddr_i, .axi_wvalid_i, .axi_wready_o,
    .axi_wdata_i, .axi_wstrb_i, .axi_bvalid_o, .axi_bready_i, .axi_bresp_o, .axi_arvalid_i, .axi_arready_o,
    .axi_araddr_i, .axi_rvalid_o, .axi_rready_i, .axi_rdata_o, .axi_rresp_o, .bus_master_request_o, .bus_grant_i,
    .bus_own_o, .mem_o, .slave_reply_i, .mem_rdata_i, .drv_func_o, .drv_func_load_o, .drv_connect_o,
    .drv_sync_clk_i, .drv_write_clk_o, .end_of_record_pulse_i, .drv_data_i, .drv_data_o, .drv_data_oe_o);
  trdma_partner mdl_u (.clk_i(clk_i), .slow_i(slow_i), .bad_i(bad_i), .req_i(bus_master_request_o),
    .grant_o(bus_grant_i), .mem_i(mem_o), .reply_o(slave_reply_i), .mrd_o(mem_rdata_i),
    .connect_i(drv_connect_o), .wclk_i(drv_write_clk_o), .wdat_i(drv_data_o), .sync_o(drv_sync_clk_i),
    .eor_o(end_of_record_pulse_i), .dat_o(drv_data_i));
  // ----------------------------------------
  // register bus tasks
  // ----------------------------------------
  task automatic wr(input logic [2:0] r, input logic [15:0] v);
    @(posedge clk_i);
    axi_awaddr_i <= {r, 2'b00};
    axi_wdata_i <= {16'h0000, v};
    axi_awvalid_i <= 1'b1;
    axi_wvalid_i <= 1'b1;
    axi_bready_i <= 1'b1;
    do begin
      @(posedge clk_i);
      if (axi_awready_o) axi_awvalid_i <= 1'b0;
      if (axi_wready_o) axi_wvalid_i <= 1'b0;
    end while (!axi_bvalid_o);
    axi_bready_i <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] r);
    @(posedge clk_i);
    axi_araddr_i <= {r, 2'b00};
    axi_arvalid_i <= 1'b1;
    axi_rready_i <= 1'b1;
    do begin
      @(posedge clk_i);
      if (axi_arready_o) axi_arvalid_i <= 1'b0;
    end while (!axi_rvalid_o);
    d = axi_rdata_o;
    e = axi_rresp_o;
    axi_rready_i <= 1'b0;
  endtask
  task automatic ck(input logic [2:0] r, input logic [31:0] x);
    rd(r);
    `CHK("register", x, d)
  endtask
  // pointer write while busy must be dropped
  task automatic go(input logic [4:0] fn, input logic [15:0] p, input logic [15:0] c, input logic [1:0] x);
    int k;
    wr(REG_PTR, p);
    wr(REG_MCNT, c);
    wr(REG_CTL, {6'h00, x, 2'b00, fn, 1'b1});
    rd(REG_CTL);
    `CHK("busy", 1'b0, d[CTL_READY])
    `CHK("function", {fn, 1'b1}, drv_func_o)
    wr(REG_PTR, 16'h0FFE);
    for (k = 0; k < 500 && d[CTL_READY] !== 1'b1; k++) rd(REG_CTL);
    `CHK("ready", 1'b1, d[CTL_READY])
    `CHK("bus released", 2'b00, {bus_own_o, drv_data_oe_o})
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    #400000;
    n_mismatch++;
    wrap_up;
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rd(3'h6);
    `CHK("unmapped", RESP_SLVERR, e)
    ck(REG_CTL, 32'h00000080);
    for (i = 0; i < 16; i++) mdl_u.m[8'hA0 + i] = 16'h5A00 + 16'(i);
    go(FN_READ, 16'h0100, 16'hFFFC, 2'b00);
    for (i = 0; i < 4; i++) `CHK("memory", 16'hA500 + 16'(i), mdl_u.m[8'h80 + i])
    ck(REG_PTR, 32'h00000108);
    ck(REG_MCNT, 32'h00000000);
    ck(REG_DCNT, 32'h00000000);
    ck(REG_ERR, 32'h00000000);
    mdl_u.ncap = 0;
    go(FN_WRITE, 16'h0140, 16'hFFFE, 2'b00);
    for (i = 0; i < 2; i++) `CHK("drive word", 16'h5A00 + 16'(i), mdl_u.cap[i])
    ck(REG_ERR, 32'h00000000);
    slow_i <= 1'b1;
    go(FN_WCHK, 16'h0100, 16'hFFFC, 2'b00);
    ck(REG_ERR, 32'h00000000);
    bad_i <= 1'b1;
    go(FN_WCHK, 16'h0100, 16'hFFFC, 2'b00);
    rd(REG_ERR);
    `CHK("compare flag", 1'b1, d[ERR_CMP])
    ck(REG_OUTW, 32'h0000A501);
    // dead bank: reply never comes, and the drive ends the record before the counter overflows
    go(FN_READ, 16'h0100, 16'hFFEF, 2'b10);
    ck(REG_ERR, 32'h00000203);
    ck(REG_DCNT, 32'h0000FFFF);
    wrap_up;
  end
endmodule
